// [logic/mmf_filter_table.sv]
// 128-word message filter table with host write and read paths
// assumes host writes are single-cycle strobes on the core clock
`timescale 1ns/100ps
module mmf_filter_table
   import mmf_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_arst_n,
   mmf_tbl_if.tbl tbl
);
   logic [15:0] mem_q [TBL_WORDS];
   logic in_range;

   assign in_range = (tbl.haddr[15:7] == TBL_BASE[15:7]); // [RULE1]

   // kept in flops so the whole table clears on master reset
   for (genvar g = 0; g < TBL_WORDS; g++) begin : g_word
      always_ff @(posedge i_core_clk or negedge i_arst_n) begin
         if (!i_arst_n) begin
            mem_q[g] <= TBL_RST; // [RULE4]
         end else if (tbl.hwr && in_range && (tbl.haddr[6:0] == 7'(g))) begin
            mem_q[g] <= tbl.hwdata;
         end
      end
   end

   assign tbl.hit = mem_q[tbl.idx][tbl.sel]; // [RULE8]
   assign tbl.hrdata = in_range ? mem_q[tbl.haddr[6:0]] : 16'h0000;
endmodule

// [logic/mmf_top.sv]
// message selection and no-response timing for the simple monitor
// assumes a word decoder feeding strobes synchronous to the core clock
`timescale 1ns/100ps
// Notes on behaviour
// RULE1 - selection table is 128 sixteen-bit words at ram word address 0x0100
// RULE2 - table bit 1 for a new message: ignore it, record nothing
// RULE3 - table bit 0 for a new message: record the whole message
// RULE4 - after master reset all table words 0x0100-0x017F read zero
// RULE5 - every valid command word after an idle bus starts a filtered message
// RULE6 - table index is terminal address, transmit/receive bit, subaddress msb
// RULE7 - four words per terminal: rx 0-15, rx 16-31, tx 0-15, tx 16-31
// RULE8 - bit tested equals the low four subaddress bits
// RULE9 - configuration bits 15:14 pick one of four no-response time-outs
// RULE10 - normal time-out runs from command end to status mid-sync; code starts it at the last data word end when data precede status
// RULE11 - codes give 16/21/80/138 us, or 61/66/122/180 us terminal-to-terminal
// RULE12 - lookup finishes before any word of the message is recorded
module mmf_top
   import mmf_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_arst_n,
   input wire logic i_host_wr,
   input wire logic [15:0] i_host_addr,
   input wire logic [15:0] i_host_wdata,
   output logic [15:0] o_host_rdata,
   input wire logic i_word_valid,
   input wire logic i_word_cmd,
   input wire logic i_word_ok,
   input wire logic i_word_after_gap,
   input wire logic [15:0] i_word_data,
   input wire logic i_mid_parity,
   input wire logic i_mid_sync,
   output logic o_msg_start,
   output logic o_msg_ignored,
   output logic o_rec_valid,
   output logic o_rec_cmd_sync,
   output logic [15:0] o_rec_word,
   output logic o_no_response
);
   mmf_tbl_if tbl();
   mmf_state_t state_q;
   logic [15:0] cfg_q;
   logic [15:0] cmd_q;
   logic ignored_q;
   logic rtrt_q;
   logic bcast_q;
   logic [5:0] left_q;
   logic new_msg;
   logic cmd_bcast;
   logic norm_start;
   logic norm_stop;
   logic norm_exp;
   logic rtrt_start;
   logic rtrt_stop;
   logic rtrt_exp;
   logic timeout;
   logic [7:0] norm_lim;
   logic [7:0] rtrt_lim;

   // data words carried by a command; mode codes carry one when code msb is set
   function automatic logic [5:0] data_words(input logic [15:0] cw);
      logic [4:0] sa;
      sa = cw[CW_SA_MSB:CW_SA_LSB];
      if (sa == SA_MODE_LO || sa == SA_MODE_HI) begin
         data_words = {5'h00, cw[CW_WC_MSB]};
      end else if (cw[CW_WC_MSB:0] == 5'h00) begin
         data_words = 6'h20;
      end else begin
         data_words = {1'b0, cw[CW_WC_MSB:0]};
      end
   endfunction

   mmf_filter_table u_table (
      .i_core_clk(i_core_clk),
      .i_arst_n(i_arst_n),
      .tbl(tbl.tbl)
   );

   assign new_msg = (state_q == ST_IDLE) && i_word_valid && i_word_cmd && i_word_ok
      && i_word_after_gap; // [RULE5]
   assign cmd_bcast = (i_word_data[CW_RT_MSB:CW_RT_LSB] == RT_BCAST);

   // table word = base + {rt, t/r, sa msb}, four words per terminal
   assign tbl.idx = {cmd_q[CW_RT_MSB:CW_RT_LSB], cmd_q[CW_TR], cmd_q[CW_SA_MSB]}; // [RULE6] [RULE7]
   assign tbl.sel = cmd_q[CW_SA_LSB + 3:CW_SA_LSB]; // [RULE8]
   assign tbl.haddr = i_host_addr;
   assign tbl.hwdata = i_host_wdata;
   assign tbl.hwr = i_host_wr;

   // host side: configuration register and read data
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cfg_q <= CFG_RST;
      end else if (i_host_wr && i_host_addr == CFG_ADDR) begin
         cfg_q <= i_host_wdata;
      end
   end

   // bit 13 is write-only and reads back zero
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_host_rdata <= 16'h0000;
      end else if (i_host_addr == CFG_ADDR) begin
         o_host_rdata <= cfg_q & ~(16'h0001 << CFG_WO_BIT);
      end else begin
         o_host_rdata <= tbl.hrdata;
      end
   end

   assign norm_lim = TO_NORM_US[cfg_q[CFG_TO_MSB:CFG_TO_LSB]]; // [RULE9] [RULE11]
   assign rtrt_lim = TO_RTRT_US[cfg_q[CFG_TO_MSB:CFG_TO_LSB]]; // [RULE11]

   // normal time-out starts at the end of the word after which status is due
   assign norm_start = (new_msg && !cmd_bcast
         && (i_word_data[CW_TR] || data_words(i_word_data) == 6'h00))
      || (state_q == ST_RXDATA && i_word_valid && !i_word_cmd && left_q == 6'h01 && !bcast_q)
      || (state_q == ST_TXDATA && i_word_valid && left_q == 6'h01 && rtrt_q); // [RULE10]
   assign norm_stop = i_mid_sync && state_q == ST_STATUS; // [RULE10]
   // terminal-to-terminal timing runs from mid-parity of the receive command
   assign rtrt_start = i_mid_parity && state_q == ST_IDLE; // [RULE11]
   assign rtrt_stop = i_mid_sync && state_q == ST_TXDATA; // [RULE11]
   assign timeout = (norm_exp && state_q == ST_STATUS)
      || (rtrt_exp && rtrt_q && (state_q == ST_RTRT_STAT || state_q == ST_TXDATA));

   mmf_us_timer u_norm_tmr (
      .i_core_clk(i_core_clk),
      .i_arst_n(i_arst_n),
      .i_start(norm_start),
      .i_stop(norm_stop),
      .i_limit_us(norm_lim),
      .o_expired(norm_exp)
   );

   mmf_us_timer u_rtrt_tmr (
      .i_core_clk(i_core_clk),
      .i_arst_n(i_arst_n),
      .i_start(rtrt_start),
      .i_stop(rtrt_stop),
      .i_limit_us(rtrt_lim),
      .o_expired(rtrt_exp)
   );

   // message sequencer
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_q <= ST_IDLE;
         cmd_q <= 16'h0000;
         left_q <= 6'h00;
         rtrt_q <= 1'b0;
         bcast_q <= 1'b0;
      end else if (timeout) begin
         state_q <= ST_IDLE;
         rtrt_q <= 1'b0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (new_msg) begin
                  cmd_q <= i_word_data;
                  bcast_q <= cmd_bcast;
                  rtrt_q <= 1'b0;
                  state_q <= ST_LOOKUP; // [RULE12]
               end
            end
            ST_LOOKUP: begin
               left_q <= data_words(cmd_q);
               if (cmd_q[CW_TR]) begin
                  state_q <= bcast_q ? ST_IDLE : ST_STATUS;
               end else if (data_words(cmd_q) != 6'h00) begin
                  state_q <= ST_RXDATA;
               end else begin
                  state_q <= bcast_q ? ST_IDLE : ST_STATUS;
               end
            end
            ST_RXDATA: begin
               if (i_word_valid && i_word_cmd && left_q == data_words(cmd_q)) begin
                  // second contiguous command: terminal-to-terminal transfer
                  rtrt_q <= 1'b1;
                  left_q <= data_words(i_word_data);
                  state_q <= ST_RTRT_STAT;
               end else if (i_word_valid) begin
                  left_q <= left_q - 6'h01;
                  if (left_q == 6'h01) begin
                     state_q <= bcast_q ? ST_IDLE : ST_STATUS;
                  end
               end
            end
            ST_RTRT_STAT: begin
               if (i_word_valid) begin
                  state_q <= (left_q == 6'h00) ? ST_STATUS : ST_TXDATA;
               end
            end
            ST_TXDATA: begin
               if (i_word_valid) begin
                  left_q <= left_q - 6'h01;
                  if (left_q == 6'h01) begin
                     state_q <= rtrt_q ? ST_STATUS : ST_IDLE;
                  end
               end
            end
            ST_STATUS: begin
               if (i_word_valid) begin
                  state_q <= (left_q != 6'h00 && !rtrt_q) ? ST_TXDATA : ST_IDLE;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // filter decision is taken in the lookup cycle, before anything is recorded
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ignored_q <= 1'b0;
      end else if (state_q == ST_LOOKUP) begin
         ignored_q <= tbl.hit; // [RULE2] [RULE3]
      end
   end

   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_msg_start <= 1'b0;
         o_msg_ignored <= 1'b0;
         o_no_response <= 1'b0;
      end else begin
         o_msg_start <= (state_q == ST_LOOKUP);
         o_msg_ignored <= (state_q == ST_LOOKUP) && tbl.hit; // [RULE2]
         o_no_response <= timeout;
      end
   end

   // record path: command word once the lookup clears it, then message words
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_rec_valid <= 1'b0;
         o_rec_cmd_sync <= 1'b0;
         o_rec_word <= 16'h0000;
      end else if (state_q == ST_LOOKUP) begin
         o_rec_valid <= !tbl.hit; // [RULE3] [RULE12]
         o_rec_cmd_sync <= 1'b1;
         o_rec_word <= cmd_q;
      end else begin
         o_rec_valid <= i_word_valid && !ignored_q
            && state_q != ST_IDLE; // [RULE2]
         o_rec_cmd_sync <= i_word_cmd;
         o_rec_word <= i_word_data;
      end
   end

   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_arst_n);

   chk_new_message: assert property (new_msg |=> state_q == ST_LOOKUP ##1 o_msg_start) // [RULE5]
      else $error("valid command after gap did not start a message");
   chk_ignore_silent: assert property (
      (state_q == ST_LOOKUP && tbl.hit) |=> !o_rec_valid && o_msg_ignored) // [RULE2]
      else $error("ignored message produced a record");
   chk_ignore_whole: assert property (
      (ignored_q && state_q != ST_IDLE && state_q != ST_LOOKUP) |=> !o_rec_valid) // [RULE2]
      else $error("word of an ignored message was recorded");
   chk_record_cmd: assert property ((state_q == ST_LOOKUP && !tbl.hit)
      |=> o_rec_valid && o_rec_cmd_sync && o_rec_word == $past(cmd_q)) // [RULE3]
      else $error("monitored command word not recorded");
   chk_lookup_first: assert property (new_msg |=> !o_rec_valid ##1
      (o_rec_valid != o_msg_ignored)) // [RULE12]
      else $error("record before lookup finished");
   chk_index_form: assert property (new_msg |=> tbl.idx == {$past(i_word_data[15:9])}
      && tbl.sel == $past(i_word_data[8:5])) // [RULE6] [RULE7] [RULE8]
      else $error("table index not taken from command fields");
   chk_limit_select: assert property ((i_host_wr && i_host_addr == CFG_ADDR)
      |=> norm_lim == TO_NORM_US[$past(i_host_wdata[15:14])]
      && rtrt_lim == TO_RTRT_US[$past(i_host_wdata[15:14])]) // [RULE9] [RULE11]
      else $error("time-out limit does not follow configuration");
   chk_timeout_end: assert property (timeout |=> state_q == ST_IDLE && o_no_response) // [RULE10]
      else $error("time-out did not end the message");
   chk_cfg_read: assert property ((i_host_addr == CFG_ADDR && !i_host_wr)
      |=> o_host_rdata[15:14] == $past(cfg_q[15:14]) && !o_host_rdata[13]) // [RULE9]
      else $error("configuration read back wrong");

   cov_ignored: cover property (state_q == ST_LOOKUP && tbl.hit);
   cov_recorded: cover property (state_q == ST_LOOKUP && !tbl.hit);
   cov_rtrt: cover property (state_q == ST_RXDATA ##1 state_q == ST_RTRT_STAT);
   cov_timeout: cover property (o_no_response);
endmodule

// [logic/mmf_us_timer.sv]
// no-response timer counting whole microseconds from a start pulse
// assumes start, stop and limit are synchronous to the core clock
`timescale 1ns/100ps
module mmf_us_timer
   import mmf_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_arst_n,
   input wire logic i_start,
   input wire logic i_stop,
   input wire logic [7:0] i_limit_us,
   output logic o_expired
);
   localparam logic [6:0] PRE_LAST = 7'(US_CYCLES - 1);
   logic run_q;
   logic [6:0] pre_q;
   logic [7:0] us_q;
   logic tick;

   assign tick = run_q && (pre_q == PRE_LAST);

   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         run_q <= 1'b0;
         pre_q <= 7'h00;
         us_q <= 8'h00;
      end else if (i_start) begin
         run_q <= 1'b1;
         pre_q <= 7'h00;
         us_q <= 8'h00;
      end else if (i_stop || (tick && (us_q + 8'h01 == i_limit_us))) begin
         run_q <= 1'b0;
      end else if (run_q) begin
         pre_q <= tick ? 7'h00 : pre_q + 7'h01;
         us_q <= tick ? us_q + 8'h01 : us_q;
      end
   end

   // restart wins over a stale expiry in the same cycle
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_expired <= 1'b0;
      end else begin
         o_expired <= !i_start && !i_stop && tick && (us_q + 8'h01 == i_limit_us);
      end
   end

   chk_expire_run: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      o_expired |-> $past(run_q) && !run_q) // [RULE10]
      else $error("timer expired while not running");
endmodule

// [pkg/mmf_pkg.sv]
// constants and types for the monitor message filter
// assumes a 125 MHz core clock and 16-bit host words
package mmf_pkg;
   // filter table placement in the shared ram
   localparam logic [15:0] TBL_BASE = 16'h0100;
   localparam int TBL_WORDS = 128;
   localparam logic [15:0] TBL_RST = 16'h0000;
   // monitor_configuration register
   localparam logic [15:0] CFG_ADDR = 16'h0029;
   localparam logic [15:0] CFG_RST = 16'h0000;
   localparam int CFG_TO_MSB = 15;
   localparam int CFG_TO_LSB = 14;
   localparam int CFG_WO_BIT = 13;
   // command word fields
   localparam int CW_RT_MSB = 15;
   localparam int CW_RT_LSB = 11;
   localparam int CW_TR = 10;
   localparam int CW_SA_MSB = 9;
   localparam int CW_SA_LSB = 5;
   localparam int CW_WC_MSB = 4;
   localparam logic [4:0] RT_BCAST = 5'h1F;
   localparam logic [4:0] SA_MODE_LO = 5'h00;
   localparam logic [4:0] SA_MODE_HI = 5'h1F;
   // timing: one microsecond tick in core clocks
   localparam int CLK_NS = 8;
   localparam int US_NS = 1000;
   localparam int US_CYCLES = US_NS / CLK_NS;
   // time-outs in microseconds: 16, 21, 80, 138
   localparam logic [7:0] TO_NORM_US [4] = '{8'h10, 8'h15, 8'h50, 8'h8A};
   // terminal-to-terminal: 61, 66, 122, 180
   localparam logic [7:0] TO_RTRT_US [4] = '{8'h3D, 8'h42, 8'h7A, 8'hB4};
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_LOOKUP = 6'h02,
      ST_RXDATA = 6'h04,
      ST_RTRT_STAT = 6'h08,
      ST_TXDATA = 6'h10,
      ST_STATUS = 6'h20
   } mmf_state_t;
endpackage

// [pkg/mmf_tbl_if.sv]
// carrier between the message sequencer and the filter table
// assumes both ends share the core clock
`timescale 1ns/100ps
interface mmf_tbl_if;
   logic [6:0] idx;
   logic [3:0] sel;
   logic hit;
   logic [15:0] haddr;
   logic [15:0] hwdata;
   logic [15:0] hrdata;
   logic hwr;
   modport ctrl(output idx, sel, haddr, hwdata, hwr, input hit, hrdata);
   modport tbl(input idx, sel, haddr, hwdata, hwr, output hit, hrdata);
endinterface

// [tb/mmf_bus_model.sv]
// stand-in for the bus word decoder that feeds the monitor message filter
// assumes the bench calls send_word from one process, on the core clock
`timescale 1ns/100ps
module mmf_bus_model (
   input wire logic i_core_clk,
   output logic o_word_valid,
   output logic o_word_cmd,
   output logic o_word_ok,
   output logic o_word_after_gap,
   output logic [15:0] o_word_data,
   output logic o_mid_parity,
   output logic o_mid_sync
);
   initial begin
      o_word_valid = 1'b0;
      o_word_cmd = 1'b0;
      o_word_ok = 1'b0;
      o_word_after_gap = 1'b0;
      o_word_data = 16'h0000;
      o_mid_parity = 1'b0;
      o_mid_sync = 1'b0;
   end
   // five edges per word keeps strobes well over three cycles apart
   // qualifiers turn to the inverse after the strobe so stale values never pass
   task automatic send_word(input logic s, input logic [15:0] d, input logic gap,
                            input logic ok);
      @(posedge i_core_clk);
      o_mid_sync <= 1'b1;
      @(posedge i_core_clk);
      o_mid_sync <= 1'b0;
      @(posedge i_core_clk);
      o_mid_parity <= 1'b1;
      @(posedge i_core_clk);
      o_mid_parity <= 1'b0;
      o_word_valid <= 1'b1;
      o_word_cmd <= s;
      o_word_ok <= ok;
      o_word_after_gap <= gap;
      o_word_data <= d;
      @(posedge i_core_clk);
      o_word_valid <= 1'b0;
      o_word_cmd <= ~s;
      o_word_ok <= ~ok;
      o_word_after_gap <= ~gap;
      o_word_data <= ~d;
   endtask
endmodule

// [tb/mmf_top_bench.sv]
// self-checking bench for the monitor message filter top
// assumes the bus model stands in for the word decoder; host port driven here
`timescale 1ns/100ps
module mmf_top_bench
   import mmf_pkg::*;
();
   logic core_clk = 1'b0;
   logic arst_n = 1'b0;
   logic host_wr = 1'b0;
   logic [15:0] host_addr = 16'h0000;
   logic [15:0] host_wdata = 16'h0000;
   logic [15:0] host_rdata, word_data, rec_word;
   logic word_valid, word_cmd, word_ok, word_gap, mid_parity, mid_sync;
   logic msg_start, msg_ignored, rec_valid, rec_cmd_sync, no_response;
   int err_count = 0;
   int cmp_count = 0;
   int rec_cnt = 0;
   always #4 core_clk = ~core_clk;
   always @(posedge core_clk) if (rec_valid === 1'b1) rec_cnt <= rec_cnt + 1;
   mmf_top i_mmf_top (.i_core_clk(core_clk), .i_arst_n(arst_n), .i_host_wr(host_wr),
      .i_host_addr(host_addr), .i_host_wdata(host_wdata), .o_host_rdata(host_rdata),
      .i_word_valid(word_valid), .i_word_cmd(word_cmd), .i_word_ok(word_ok),
      .i_word_after_gap(word_gap), .i_word_data(word_data), .i_mid_parity(mid_parity),
      .i_mid_sync(mid_sync), .o_msg_start(msg_start), .o_msg_ignored(msg_ignored),
      .o_rec_valid(rec_valid), .o_rec_cmd_sync(rec_cmd_sync), .o_rec_word(rec_word),
      .o_no_response(no_response));
   mmf_bus_model i_mmf_bus_model (.i_core_clk(core_clk), .o_word_valid(word_valid),
      .o_word_cmd(word_cmd), .o_word_ok(word_ok), .o_word_after_gap(word_gap),
      .o_word_data(word_data), .o_mid_parity(mid_parity), .o_mid_sync(mid_sync));
   task automatic give_verdict();
      if (err_count == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_cnt(input string what, input int exp, input int got);
      cmp_count++;
      if (got != exp) begin
         err_count++;
         $display("unexpected %s: expected %0d seen %0d", what, exp, got);
      end
   endtask
   task automatic host_write(input logic [15:0] a, input logic [15:0] d);
      @(posedge core_clk);
      host_wr <= 1'b1;
      host_addr <= a;
      host_wdata <= d;
      @(posedge core_clk);
      host_wr <= 1'b0;
   endtask
   task automatic host_read(input logic [15:0] a, output logic [15:0] d);
      @(posedge core_clk);
      host_addr <= a;
      @(posedge core_clk);
      #1 d = host_rdata;
   endtask
   // called at the strobe's sampling edge: the record stands for the cycle after it
   task automatic check_rec(input logic [15:0] w, input logic s);
      #1;
      chk_word("rec_valid", 16'h0001, {15'h0000, rec_valid});
      chk_word("rec_word", w, rec_word);
      chk_word("rec_cmd_sync", {15'h0000, s}, {15'h0000, rec_cmd_sync});
   endtask
   // one-word message; status carries the terminal address of the command
   task automatic run_msg(input logic [15:0] cmd, input logic tx, input logic ign);
      int n0;
      logic [15:0] st;
      n0 = rec_cnt;
      st = {cmd[15:11], 11'h000};
      i_mmf_bus_model.send_word(1'b1, cmd, 1'b1, 1'b1);
      @(posedge core_clk);
      #1;
      chk_word("msg_start", 16'h0001, {15'h0000, msg_start});
      chk_word("msg_ignored", {15'h0000, ign}, {15'h0000, msg_ignored});
      chk_word("rec_valid", {15'h0000, ~ign}, {15'h0000, rec_valid});
      if (!ign) chk_word("rec_word", cmd, rec_word);
      i_mmf_bus_model.send_word(tx, tx ? st : 16'h5A5A, 1'b0, 1'b1);
      if (!ign) check_rec(tx ? st : 16'h5A5A, tx);
      i_mmf_bus_model.send_word(~tx, tx ? 16'hA5A5 : st, 1'b0, 1'b1);
      if (!ign) check_rec(tx ? 16'hA5A5 : st, ~tx);
      repeat (3) @(posedge core_clk);
      #1;
      chk_cnt("records", ign ? n0 : n0 + 3, rec_cnt);
   endtask
   task automatic t_reset();
      logic [15:0] v;
      for (int i = 0; i < 128; i++) begin
         host_read(16'h0100 + 16'(i), v);
         chk_word("table word", 16'h0000, v);
      end
      host_read(16'h0029, v);
      chk_word("config", 16'h0000, v);
   endtask
   task automatic t_config();
      logic [15:0] v;
      host_write(16'h0029, 16'hE000);
      host_read(16'h0029, v);
      chk_word("config", 16'hC000, v);
      host_write(16'h0180, 16'hFFFF);
      host_read(16'h0180, v);
      chk_word("past table", 16'h0000, v);
      host_write(16'h0029, 16'h0000);
   endtask
   // neighbours differ from the blocked command in one index field or bit, except 0x0861, which differs in several
   task automatic t_filter();
      logic [15:0] cmds [6] = '{16'h17C1, 16'h15C1, 16'h17A1, 16'h13C1, 16'h1FC1, 16'h0861};
      logic [15:0] v;
      host_write(16'h010B, 16'h4000);
      host_read(16'h010B, v);
      chk_word("table word", 16'h4000, v);
      for (int i = 0; i < 6; i++) run_msg(cmds[i], cmds[i][10], i == 0);
      host_write(16'h010B, 16'h0000);
      run_msg(16'h17C1, 1'b1, 1'b0);
   endtask
   task automatic t_idle_words();
      int n0;
      n0 = rec_cnt;
      i_mmf_bus_model.send_word(1'b1, 16'h0861, 1'b0, 1'b1);
      i_mmf_bus_model.send_word(1'b1, 16'h0861, 1'b1, 1'b0);
      i_mmf_bus_model.send_word(1'b0, 16'h0861, 1'b1, 1'b1);
      repeat (4) @(posedge core_clk);
      #1;
      chk_cnt("records", n0, rec_cnt);
   endtask
   // the longest limit is about 17k cycles, so the 18000-cycle bound stays just above it
   task automatic t_timeout();
      int lim [4] = '{16, 21, 80, 138};
      int n;
      for (int c = 0; c < 4; c++) begin
         host_write(16'h0029, {c[1:0], 14'h0000});
         i_mmf_bus_model.send_word(1'b1, 16'h15C1, 1'b1, 1'b1);
         n = 0;
         do begin
            @(posedge core_clk);
            #1;
            n++;
         end while (n < 18000 && no_response !== 1'b1);
         chk_cnt("timeout cycles", lim[c] * 125 + 1, n);
         if (n >= 18000) give_verdict();
      end
      host_write(16'h0029, 16'h0000);
   endtask
   // receive command, transmit command and transmit status, then no data word
   task automatic t_rtrt();
      int n0;
      int n;
      n0 = rec_cnt;
      host_write(16'h0029, 16'h4000);
      i_mmf_bus_model.send_word(1'b1, 16'h0861, 1'b1, 1'b1);
      i_mmf_bus_model.send_word(1'b1, 16'h1461, 1'b0, 1'b1);
      i_mmf_bus_model.send_word(1'b1, 16'h1000, 1'b0, 1'b1);
      n = 0;
      do begin
         @(posedge core_clk);
         #1;
         n++;
      end while (n < 9000 && no_response !== 1'b1);
      // receive mid-parity is sampled eleven edges before the status strobe
      chk_cnt("rt-rt timeout cycles", 66 * 125 - 10, n);
      chk_cnt("records", n0 + 3, rec_cnt);
      host_write(16'h0029, 16'h0000);
      if (n >= 9000) give_verdict();
   endtask
   task automatic t_rereset();
      logic [15:0] v;
      host_write(16'h017F, 16'hFFFF);
      @(posedge core_clk);
      arst_n <= 1'b0;
      repeat (4) @(posedge core_clk);
      arst_n <= 1'b1;
      host_read(16'h017F, v);
      chk_word("table word", 16'h0000, v);
   endtask
   initial begin
      repeat (4) @(posedge core_clk);
      arst_n <= 1'b1;
      t_reset();
      t_config();
      t_filter();
      t_idle_words();
      t_timeout();
      t_rtrt();
      t_rereset();
      give_verdict();
   end
endmodule
